// [src/pdpr_top.sv]
// Register bank for port direction, output latch and pull-up control
`timescale 1ns/100ps
`default_nettype none
module pdpr_top (
  input  wire logic                i_mclk,
  input  wire logic                i_rst_n,
  input  wire pdpr_pkg::pdpr_req_t i_req,
  output logic [7:0]               o_rdata,
  output logic                     o_rvalid,
  input  wire logic [5:0][7:0]     i_pin,
  input  wire logic [5:0][7:0]     i_alt_out,
  input  wire logic                i_ext_clk_mode,
  output logic [5:0][7:0]          o_pin_out,
  output logic [5:0][7:0]          o_pin_oe_n,
  output logic [5:0][7:0]          o_pullup_en
);

  pdpr_pkg::pdpr_bank_t dir;
  pdpr_pkg::pdpr_bank_t data;
  pdpr_pkg::pdpr_bank_t pu;
  pdpr_pkg::pdpr_bank_t next_dir;
  pdpr_pkg::pdpr_bank_t next_data;
  pdpr_pkg::pdpr_bank_t next_pu;
  pdpr_pkg::pdpr_bank_t next_pin_oe_n;
  pdpr_pkg::pdpr_bank_t next_pullup_en;
  pdpr_pkg::pdpr_bank_t pin_s;
  pdpr_pkg::pdpr_bank_t data_rd;
  logic [7:0]           next_rdata;
  logic                 next_rvalid;

  logic [5:0]           hit_data;
  logic [5:0]           hit_dir;
  logic [5:0]           hit_pu;
  logic [7:0]           sel_old;
  logic [7:0]           sel_mask;
  logic [7:0]           sel_fill;
  logic [7:0]           sel_rd;
  logic [7:0]           merged;

  // Pins come from outside the clock domain
  pdpr_sync #(
    .W (48)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (i_pin),
    .o_sync  (pin_s)
  );

  pdpr_wmerge u_wmerge (
    .i_bit_op  (i_req.bit_op),
    .i_bit_sel (i_req.bit_sel),
    .i_wdata   (i_req.wdata),
    .i_old     (sel_old),
    .i_mask    (sel_mask),
    .i_fill    (sel_fill),
    .o_new     (merged)
  );

  // Address decode and read value per port
  genvar p;
  generate
    for (p = 0; p < pdpr_pkg::PDPR_NPORT; p++) begin : g_port
      logic [7:0] rd_mix;
      assign hit_data[p] = (i_req.addr == pdpr_pkg::PDPR_DATA_ADDR[p]);
      assign hit_dir[p]  = (i_req.addr == pdpr_pkg::PDPR_DIR_ADDR[p]);
      assign hit_pu[p]   = (pdpr_pkg::PDPR_PU_MASK[p] != 8'h00)
                         && (i_req.addr == pdpr_pkg::PDPR_PU_ADDR[p]);
      // Input pins read the pin, output pins read the latch
      assign rd_mix = (dir[p] & pin_s[p]) | (~dir[p] & data[p]);
      if (p == pdpr_pkg::PDPR_P12_SLOT) begin : g_osc
        assign data_rd[p] = rd_mix & pdpr_pkg::PDPR_IMPL_MASK[p]
                          & ~({8{i_ext_clk_mode}} & pdpr_pkg::PDPR_OSC_BITS);
      end else begin : g_plain
        assign data_rd[p] = rd_mix & pdpr_pkg::PDPR_IMPL_MASK[p];
      end
    end
  endgenerate

  // Selected register for a write merge or a read
  always_comb begin
    sel_old  = 8'h00;
    sel_mask = 8'h00;
    sel_fill = 8'h00;
    sel_rd   = pdpr_pkg::PDPR_RD_NONE;
    for (int i = 0; i < pdpr_pkg::PDPR_NPORT; i++) begin
      if (hit_data[i]) begin
        sel_old  = data[i];
        sel_mask = pdpr_pkg::PDPR_IMPL_MASK[i];
        sel_fill = pdpr_pkg::PDPR_DATA_RST;
        sel_rd   = data_rd[i];
      end
      if (hit_dir[i]) begin
        sel_old  = dir[i];
        sel_mask = pdpr_pkg::PDPR_IMPL_MASK[i];
        // Unimplemented direction bits read as ones
        sel_fill = pdpr_pkg::PDPR_DIR_RST;
        sel_rd   = dir[i];
      end
      if (hit_pu[i]) begin
        sel_old  = pu[i];
        sel_mask = pdpr_pkg::PDPR_PU_MASK[i];
        sel_fill = pdpr_pkg::PDPR_PU_RST;
        sel_rd   = pu[i];
      end
    end
  end

  // Register next values
  always_comb begin
    next_dir  = dir;
    next_data = data;
    next_pu   = pu;
    for (int i = 0; i < pdpr_pkg::PDPR_NPORT; i++) begin
      if (i_req.wr && hit_dir[i]) begin
        next_dir[i] = merged;
      end
      if (i_req.wr && hit_data[i]) begin
        // Latch always updates, pin follows only in output mode
        next_data[i] = merged;
      end
      if (i_req.wr && hit_pu[i]) begin
        next_pu[i] = merged;
      end
    end
    if (!i_rst_n) begin
      next_dir  = {pdpr_pkg::PDPR_NPORT{pdpr_pkg::PDPR_DIR_RST}};
      next_data = {pdpr_pkg::PDPR_NPORT{pdpr_pkg::PDPR_DATA_RST}};
      next_pu   = {pdpr_pkg::PDPR_NPORT{pdpr_pkg::PDPR_PU_RST}};
    end
  end

  // Pin drive and pull-up next values
  always_comb begin
    next_pin_oe_n  = '1;
    next_pullup_en = '0;
    for (int i = 0; i < pdpr_pkg::PDPR_NPORT; i++) begin
      if (pdpr_pkg::PDPR_OD_PORT[i]) begin
        // Open-drain: drive only a low level
        next_pin_oe_n[i] = ~(~next_dir[i] & ~next_data[i]
                             & pdpr_pkg::PDPR_IMPL_MASK[i]);
      end else begin
        next_pin_oe_n[i] = ~(~next_dir[i] & pdpr_pkg::PDPR_IMPL_MASK[i]);
      end
      next_pullup_en[i] = next_pu[i] & next_dir[i] & ~i_alt_out[i]
                        & pdpr_pkg::PDPR_PU_MASK[i];
    end
    next_rdata  = (i_req.rd && i_rst_n) ? sel_rd : pdpr_pkg::PDPR_RD_NONE;
    next_rvalid = i_req.rd && i_rst_n;
    if (!i_rst_n) begin
      next_pullup_en = '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    dir         <= next_dir;
    data        <= next_data;
    pu          <= next_pu;
    o_pin_out   <= next_data;
    o_pin_oe_n  <= next_pin_oe_n;
    o_pullup_en <= next_pullup_en;
    o_rdata     <= next_rdata;
    o_rvalid    <= next_rvalid;
  end

endmodule : pdpr_top
`default_nettype wire

// [src/pdpr_pkg.sv]
// Constants, register map and bus types of the port direction, data and pull-up register bank
//
// What this block does
// - Every pin has its own direction bit, one bit per pin.
// - Output driver is on when the direction bit selects output (open-drain port 6: only for a low latch bit), off for input.
// - Reset loads all ones into every direction register.
// - All direction, data and pull-up registers take 1-bit and 8-bit accesses.
// - Data writes go to the output latch, which drives output-mode pins.
// - Reading a data bit of an input pin returns the sampled pin level.
// - Reading a data bit of an output pin returns the latch, not the pin.
// - Oscillator-shared port 12 latch bits read zero in external clock input mode.
// - Pull-up bits only for port0 0-1, port1, port3 0-3, port12 bit 0.
// - Pull-up bit 1 requests the on-chip pull-up, 0 leaves it off.
// - Pull-up applies only when its bit is set and the pin is input.
// - Pull-up stays off for output pins and alternate-function outputs.
// - Reset clears all pull-up registers, no pull-up connected.
// - Latch writes in input mode update the latch but leave the pin alone.
package pdpr_pkg;

  localparam int PDPR_NPORT = 6;
  localparam int PDPR_W     = 8;

  // Port slots: 0=port0 1=port1 2=port2 3=port3 4=port6 5=port12
  localparam logic [5:0][15:0] PDPR_DATA_ADDR = {16'hFF0C, 16'hFF06, 16'hFF03,
                                                 16'hFF02, 16'hFF01, 16'hFF00};
  localparam logic [5:0][15:0] PDPR_DIR_ADDR  = {16'hFF2C, 16'hFF26, 16'hFF23,
                                                 16'hFF22, 16'hFF21, 16'hFF20};
  localparam logic [5:0][15:0] PDPR_PU_ADDR   = {16'hFF3C, 16'h0000, 16'hFF33,
                                                 16'h0000, 16'hFF31, 16'hFF30};

  // Implemented pin bits per port
  localparam logic [5:0][7:0] PDPR_IMPL_MASK = {8'h07, 8'h03, 8'h0F, 8'h0F, 8'hFF, 8'h03};
  // Bits that carry a pull-up control
  localparam logic [5:0][7:0] PDPR_PU_MASK   = {8'h01, 8'h00, 8'h0F, 8'h00, 8'hFF, 8'h03};
  // Open-drain ports (port 6)
  localparam logic [5:0]      PDPR_OD_PORT   = 6'h10;

  localparam logic [7:0] PDPR_DIR_RST  = 8'hFF;
  localparam logic [7:0] PDPR_DATA_RST = 8'h00;
  localparam logic [7:0] PDPR_PU_RST   = 8'h00;
  localparam logic [7:0] PDPR_RD_NONE  = 8'h00;

  localparam int       PDPR_P12_SLOT = 5;
  // Port 12 latch bits shared with the oscillator pins
  localparam logic [7:0] PDPR_OSC_BITS = 8'h06;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
  } pdpr_req_t;

  typedef logic [5:0][7:0] pdpr_bank_t;

endpackage : pdpr_pkg

// [src/pdpr_sync.sv]
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module pdpr_sync #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  always_comb begin
    next_meta = i_rst_n ? i_async : '0;
    next_sync = i_rst_n ? meta : '0;
  end

  always_ff @(posedge i_mclk) begin
    meta   <= next_meta;
    o_sync <= next_sync;
  end

endmodule : pdpr_sync
`default_nettype wire

// [src/pdpr_wmerge.sv]
// Merge of a 1-bit or 8-bit write into a register byte
`timescale 1ns/100ps
`default_nettype none
module pdpr_wmerge (
  input  wire logic       i_bit_op,
  input  wire logic [2:0] i_bit_sel,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_old,
  input  wire logic [7:0] i_mask,
  input  wire logic [7:0] i_fill,
  output logic      [7:0] o_new
);

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      logic raw;
      // Bit op touches only the selected bit
      assign raw      = i_bit_op ? ((i_bit_sel == 3'(b)) ? i_wdata[0] : i_old[b])
                                 : i_wdata[b];
      // Absent bits keep their fixed value
      assign o_new[b] = i_mask[b] ? raw : i_fill[b];
    end
  endgenerate

endmodule : pdpr_wmerge
`default_nettype wire

// [verif/pdpr_chk.sv]
// Assertion checker for the port register bank
`timescale 1ns/100ps
`default_nettype none
module pdpr_chk (
  input wire logic                i_mclk,
  input wire logic                i_rst_n,
  input wire pdpr_pkg::pdpr_req_t i_req,
  input wire logic [7:0]          o_rdata,
  input wire logic                o_rvalid,
  input wire logic [5:0][7:0]     i_alt_out,
  input wire logic [5:0][7:0]     o_pin_out,
  input wire logic [5:0][7:0]     o_pin_oe_n,
  input wire logic [5:0][7:0]     o_pullup_en
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Byte write to one address
  sequence s_wr(a);
    i_req.wr && !i_req.bit_op && i_req.addr == a;
  endsequence
  AST_RVALID: assert property (i_req.rd |=> o_rvalid)
    else $error("read not answered");
  AST_IDLE: assert property (!i_req.rd |=> !o_rvalid && o_rdata == 8'h00)
    else $error("read data without read");
  AST_DIR: assert property (s_wr(16'hFF21) |=> o_pin_oe_n[1] == $past(i_req.wdata))
    else $error("direction write not on output enable");
  AST_LAT: assert property (s_wr(16'hFF01) |=> o_pin_out[1] == $past(i_req.wdata))
    else $error("latch write not on pin");
  AST_HOLD: assert property (!i_req.wr |=> $stable(o_pin_out))
    else $error("latch changed without write");
  AST_PUOUT: assert property ((o_pullup_en & ~o_pin_oe_n) == '0)
    else $error("pull-up on driven pin");
  AST_PUALT: assert property ((o_pullup_en & $past(i_alt_out)) == '0)
    else $error("pull-up on alternate output");
  AST_PUMASK: assert property ((o_pullup_en & ~pdpr_pkg::PDPR_PU_MASK) == '0)
    else $error("pull-up on pin without control");
  AST_OD: assert property ((o_pin_out[4] & ~o_pin_oe_n[4]) == 8'h00)
    else $error("open-drain pin driven high");
  AST_UNIMPL: assert property ((o_pin_oe_n | pdpr_pkg::PDPR_IMPL_MASK) == '1)
    else $error("missing pin driven");
endmodule : pdpr_chk
bind pdpr_top pdpr_chk pdpr_chk_inst (.i_mclk, .i_rst_n, .i_req, .o_rdata, .o_rvalid,
  .i_alt_out, .o_pin_out, .o_pin_oe_n, .o_pullup_en);
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the port register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                i_mclk = 1'b0;
  logic                i_rst_n = 1'b0;
  logic                i_ext_clk_mode = 1'b0;
  pdpr_pkg::pdpr_req_t i_req = '0;
  logic [7:0]          o_rdata;
  logic                o_rvalid;
  logic [5:0][7:0]     i_pin = '0, i_alt_out = '0, o_pin_out, o_pin_oe_n, o_pullup_en;
  logic [5:0][7:0]     dir, lat, pu;
  int                  n_fail = 0;
  int                  n_checks = 0;
  always #4 i_mclk = ~i_mclk;
  pdpr_top pdpr_top_inst (.i_mclk, .i_rst_n, .i_req, .o_rdata, .o_rvalid, .i_pin, .i_alt_out,
    .i_ext_clk_mode, .o_pin_out, .o_pin_oe_n, .o_pullup_en);
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic do_reset;
    @(posedge i_mclk);
    #1 i_rst_n = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    dir = '1;
    lat = '0;
    pu = '0;
  endtask : do_reset
  function automatic logic [15:0] addr_of(input int s, input int k);
    case (k)
      0: return pdpr_pkg::PDPR_DATA_ADDR[s];
      1: return pdpr_pkg::PDPR_DIR_ADDR[s];
      // Ports without pull-ups get their refused place
      2: return pdpr_pkg::PDPR_PU_MASK[s] != 0 ? pdpr_pkg::PDPR_PU_ADDR[s] : 16'hFF32 + 16'(s & 4);
      default: return 16'hFF10;
    endcase
  endfunction : addr_of
  function automatic logic [7:0] exp_rd(input int s, input int k);
    logic [7:0] v;
    v = 8'h00;
    case (k)
      0: v = (dir[s] & i_pin[s] | ~dir[s] & lat[s]) & pdpr_pkg::PDPR_IMPL_MASK[s];
      1: v = dir[s];
      2: v = pu[s];
      default: v = 8'h00;
    endcase
    if (k == 0 && s == 5 && i_ext_clk_mode) v = v & ~8'h06;
    return v;
  endfunction : exp_rd
  task automatic chk_pins;
    for (int s = 0; s < 6; s++) begin
      chk("pin_out", lat[s], o_pin_out[s]);
      chk("pin_oe_n", (s == 4 ? dir[s] | lat[s] : dir[s]) | ~pdpr_pkg::PDPR_IMPL_MASK[s],
          o_pin_oe_n[s]);
      chk("pullup_en", pu[s] & dir[s] & ~i_alt_out[s], o_pullup_en[s]);
    end
  endtask : chk_pins
  task automatic acc(input int s, input int k, input logic w, input logic r, input logic b);
    logic [7:0] e, nv;
    i_req = '{addr_of(s, k), w, r, b, 3'($urandom), 8'($urandom)};
    // Software keeps unimplemented direction bits at one
    if (k == 1 && b) begin
      i_req.wdata[0] = i_req.wdata[0] | ~pdpr_pkg::PDPR_IMPL_MASK[s][i_req.bit_sel];
    end else if (k == 1) begin
      i_req.wdata = i_req.wdata | ~pdpr_pkg::PDPR_IMPL_MASK[s];
    end
    e = exp_rd(s, k);
    @(posedge i_mclk);
    #1;
    if (r) chk("rdata", e, o_rdata);
    chk("rvalid", 8'(r), 8'(o_rvalid));
    if (w) begin
      nv = k == 0 ? lat[s] : k == 1 ? dir[s] : pu[s];
      nv = b ? (nv & ~(8'h01 << i_req.bit_sel)) | (8'(i_req.wdata[0]) << i_req.bit_sel)
             : i_req.wdata;
      case (k)
        0: lat[s] = nv & pdpr_pkg::PDPR_IMPL_MASK[s];
        1: dir[s] = nv | ~pdpr_pkg::PDPR_IMPL_MASK[s];
        2: pu[s] = nv & pdpr_pkg::PDPR_PU_MASK[s];
        default: ;
      endcase
    end
    chk_pins;
  endtask : acc
  initial begin
    int s;
    int k;
    s = $urandom(2416);
    do_reset;
    for (int n = 0; n < 900; n++) begin
      if (n % 60 == 0) begin
        i_req = '0;
        if (n == 480) do_reset;
        i_pin = 48'({$urandom, $urandom});
        i_alt_out = n % 120 == 0 ? '0 : 48'({$urandom, $urandom} & {$urandom, $urandom});
        i_ext_clk_mode = 1'($urandom);
        repeat (3) @(posedge i_mclk);
        #1;
        chk_pins;
      end
      // Sweep of every place, then random traffic
      if (n % 60 < 24) acc((n % 60) % 6, (n % 60) / 6, 1'b0, 1'b1, 1'b0);
      else acc($urandom % 6, $urandom % 4, 1'($urandom), 1'($urandom), 1'($urandom));
    end
    print_verdict;
  end
  initial begin
    #60000;
    n_fail++;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
